// file: core/bdmac_pkg.sv
// Constants and types shared by the byte DMA channel configuration block
package bdmac_pkg;

  // ----------------------------------------------------------------
  // Channel geometry
  // ----------------------------------------------------------------
  localparam int BDMAC_NUM_CH = 7;          // Channels 0..6, select code 7 is invalid
  localparam int BDMAC_SEL_W = 3;           // Width of the channel select field
  localparam int BDMAC_BASE_W = 12;         // External RAM base address width
  localparam int BDMAC_OFS_W = 10;          // Address offset / transfer size width
  localparam int BDMAC_FUNC_W = 4;          // Transfer function code width
  localparam int BDMAC_NUM_FUNC = 9;        // Assigned transfer functions
  localparam int BDMAC_BAH_W = 4;           // Writable bits of the base high register
  localparam int BDMAC_AOH_W = 2;           // Writable bits of the offset high register

  // ----------------------------------------------------------------
  // Register addresses on the special-function register port
  // ----------------------------------------------------------------
  localparam logic [7:0] BDMAC_MODE_ADDR = 8'hc7;      // Wrap enable, indirect
  localparam logic [7:0] BDMAC_SEL_ADDR = 8'hc8;       // Channel select
  localparam logic [7:0] BDMAC_CFG_ADDR = 8'hc9;       // Channel configuration
  localparam logic [7:0] BDMAC_BAL_ADDR = 8'hca;       // Base address low
  localparam logic [7:0] BDMAC_BAH_ADDR = 8'hcb;       // Base address high
  localparam logic [7:0] BDMAC_AOL_ADDR = 8'hcc;       // Offset low
  localparam logic [7:0] BDMAC_AOH_ADDR = 8'hcd;       // Offset high
  localparam logic [7:0] BDMAC_SZL_ADDR = 8'hce;       // Transfer size low
  localparam logic [7:0] BDMAC_SZH_ADDR = 8'hcf;       // Transfer size high

  // ----------------------------------------------------------------
  // Configuration register fields
  // ----------------------------------------------------------------
  localparam int BDMAC_CFG_FULL_EN_BIT = 7;  // Full-length interrupt enable
  localparam int BDMAC_CFG_MID_EN_BIT = 6;   // Mid-point interrupt enable
  localparam int BDMAC_CFG_STALL_BIT = 5;    // Stall the channel
  localparam int BDMAC_CFG_ENDIAN_BIT = 4;   // 1 = big endian
  localparam int BDMAC_CFG_FUNC_LSB = 0;     // Function select low bit
  localparam int BDMAC_MODE_WRAP_BIT = 0;    // Wrap enable in the mode register

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BDMAC_CFG_RST = 8'h00;
  localparam logic [BDMAC_BASE_W-1:0] BDMAC_BASE_RST = 12'h000;
  localparam logic [BDMAC_OFS_W-1:0] BDMAC_OFS_RST = 10'h000;
  localparam logic [BDMAC_OFS_W-1:0] BDMAC_SIZE_RST = 10'h000;
  localparam logic [BDMAC_SEL_W-1:0] BDMAC_SEL_RST = 3'h0;
  localparam logic BDMAC_WRAP_RST = 1'b0;
  localparam logic [7:0] BDMAC_RDATA_RST = 8'h00;

  // ----------------------------------------------------------------
  // Transfer function codes
  // ----------------------------------------------------------------
  typedef enum logic [BDMAC_FUNC_W-1:0] {
    BDMAC_FN_RAM_TO_ENC = 4'h0,
    BDMAC_FN_ENC_TO_RAM = 4'h1,
    BDMAC_FN_RAM_TO_CRC = 4'h2,
    BDMAC_FN_RAM_TO_SPI = 4'h3,
    BDMAC_FN_SPI_TO_RAM = 4'h4,
    BDMAC_FN_RAM_TO_AES_KEY = 4'h5,
    BDMAC_FN_RAM_TO_AES_BLK = 4'h6,
    BDMAC_FN_RAM_TO_AES_XOR = 4'h7,
    BDMAC_FN_AES_TO_RAM = 4'h8
  } bdmac_func_type;

endpackage

// file: core/bdmac_chan_if.sv
// Interface carrying the active channel's settings to the address generator and back
`timescale 1ns/1ps
interface bdmac_chan_if;
  import bdmac_pkg::*;

  // Settings of the channel the engine is working on
  logic chan_ok;                       // Active channel code is 0..6
  logic byte_done;                     // Engine finished one byte on it
  logic [BDMAC_BASE_W-1:0] base;       // Base address
  logic [BDMAC_OFS_W-1:0] ofs;         // Current offset
  logic [BDMAC_OFS_W-1:0] size;        // Transfer size
  logic wrap;                          // Wrap enable
  logic stall;                         // Stall bit
  logic big_endian;                    // Byte order
  logic full_en;                       // Full-length interrupt enable
  logic mid_en;                        // Mid-point interrupt enable
  logic [BDMAC_FUNC_W-1:0] func;       // Transfer function code
  logic [1:0] width;                   // Bytes per peripheral access
  logic [1:0] index;                   // Byte within the access
  // Results
  logic move_ok;                       // Channel may move data
  logic adv;                           // Offset advances this cycle
  logic [BDMAC_OFS_W-1:0] ofs_nxt;     // Offset after the advance
  logic full_hit;                      // Gated full-length event
  logic mid_hit;                       // Gated mid-point event
  logic [BDMAC_BASE_W-1:0] addr;       // External RAM address
  logic [BDMAC_NUM_FUNC-1:0] target;   // One-hot function target
  logic [1:0] lane;                    // Peripheral byte lane

  modport regs (
    output chan_ok, byte_done, base, ofs, size, wrap, stall, big_endian,
    output full_en, mid_en, func, width, index,
    input move_ok, adv, ofs_nxt, full_hit, mid_hit, addr, target, lane
  );
  modport gen (
    input chan_ok, byte_done, base, ofs, size, wrap, stall, big_endian,
    input full_en, mid_en, func, width, index,
    output move_ok, adv, ofs_nxt, full_hit, mid_hit, addr, target, lane
  );
endinterface

// file: core/bdmac_addr_gen.sv
// Address, offset and event generator for the active DMA channel
`timescale 1ns/1ps
module bdmac_addr_gen
  import bdmac_pkg::*;
(
  bdmac_chan_if.gen ci
);

  logic [BDMAC_OFS_W-1:0] ofs_inc;     // Offset plus one
  logic at_end;                        // Advance reaches the transfer size
  logic func_ok;                       // Function code is assigned

  // ----------------------------------------------------------------
  // Offset stepping and events
  // ----------------------------------------------------------------
  // Combinational; the top registers every result it exposes
  always_comb begin
    ofs_inc = ci.ofs + 10'h001;
    at_end = (ofs_inc == ci.size);
    // Unassigned codes move nothing
    func_ok = (ci.func < 4'(BDMAC_NUM_FUNC));
    // Stalled channel holds still until software clears it
    ci.move_ok = ci.chan_ok && func_ok && !ci.stall;
    ci.adv = ci.byte_done && ci.move_ok;
    if (ci.wrap && at_end) begin
      ci.ofs_nxt = BDMAC_OFS_RST;
    end else begin
      ci.ofs_nxt = ofs_inc;
    end
    ci.full_hit = ci.adv && at_end && ci.full_en;
    ci.mid_hit = ci.adv && (ofs_inc == {1'b0, ci.size[BDMAC_OFS_W-1:1]})
                 && (ci.size[BDMAC_OFS_W-1:1] != 9'h000) && ci.mid_en;
    // Access address is base plus offset, 12-bit wrap
    ci.addr = ci.base + {2'h0, ci.ofs};
  end

  // ----------------------------------------------------------------
  // Function decode and byte lane
  // ----------------------------------------------------------------
  always_comb begin
    ci.target = '0;
    if (ci.move_ok) begin
      ci.target[ci.func] = 1'b1;
    end
    // Single-byte accesses always use lane 0, whatever the order bit
    if (ci.width <= 2'h1) begin
      ci.lane = 2'h0;
    end else if (ci.big_endian) begin
      ci.lane = ci.width - 2'h1 - ci.index;
    end else begin
      ci.lane = ci.index;
    end
  end

endmodule

// file: core/bdmac_top.sv
// Byte DMA channel configuration registers and address generation
//
// Overview of operation
// - Config bit 7 enables full-length interrupt
// - Config bit 6 enables mid-point interrupt
// - Config bit 5 stalls channel until cleared
// - Config bit 4 picks little or big endian
// - Byte order ignored for single-byte transfers
// - Config bits 3:0 pick transfer function
// - Codes 0,1: RAM to/from encoder registers
// - Codes 2,3,4: CRC in, SPI out/in
// - Codes 5-7 AES inputs, 8 AES output
// - Base high holds address bits 11:8
// - Base low holds address bits 7:0
// - Access address is base plus offset
// - Offset high holds offset bits 9:8
// - Offset increments after every transferred byte
// - Unused upper bits read zero, ignore writes
// - Indirect registers reach the selected channel
// - All configuration fields reset to zero
// - Select codes 0-6 valid, 7 invalid
// - Full-length event when offset equals size
// - Wrap returns offset to zero at end
`timescale 1ns/1ps
module bdmac_top
  import bdmac_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic [BDMAC_SEL_W-1:0] XFER_CH_I,
  input wire logic XFER_BYTE_I,
  input wire logic [1:0] XFER_WIDTH_I,
  input wire logic [1:0] XFER_INDEX_I,
  output logic [7:0] SFR_RDATA_O,
  output logic [BDMAC_BASE_W-1:0] RAM_ADDR_O,
  output logic [BDMAC_NUM_FUNC-1:0] FUNC_SEL_O,
  output logic [1:0] BYTE_LANE_O,
  output logic XFER_OK_O,
  output logic FULL_IRQ_O,
  output logic MID_IRQ_O,
  output logic [BDMAC_NUM_CH-1:0] CH_STALL_O
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [BDMAC_SEL_W-1:0] sel_r;                    // Channel select
  logic [7:0] cfg_r [BDMAC_NUM_CH];                 // Per-channel configuration
  logic [BDMAC_BASE_W-1:0] base_r [BDMAC_NUM_CH];   // Per-channel base address
  logic [BDMAC_OFS_W-1:0] ofs_r [BDMAC_NUM_CH];     // Per-channel offset
  logic [BDMAC_OFS_W-1:0] size_r [BDMAC_NUM_CH];    // Per-channel transfer size
  logic [BDMAC_NUM_CH-1:0] wrap_r;                  // Per-channel wrap enable
  logic [7:0] rdata_r;                              // Read data holding register
  logic [7:0] rdata_nxt;                            // Read data mux
  logic [BDMAC_BASE_W-1:0] addr_r;                  // Registered RAM address
  logic [BDMAC_NUM_FUNC-1:0] target_r;              // Registered function target
  logic [1:0] lane_r;                               // Registered byte lane
  logic ok_r;                                       // Registered move permission
  logic full_r;                                     // Full-length pulse
  logic mid_r;                                      // Mid-point pulse
  logic [BDMAC_NUM_CH-1:0] stall_r;                 // Stall bits, mirrored

  logic sel_ok;                                     // Select names a real channel
  logic [BDMAC_SEL_W-1:0] sel_idx;                  // Safe index for the select
  logic act_ok;                                     // Engine channel is real
  logic [BDMAC_SEL_W-1:0] act_idx;                  // Safe index for the engine

  bdmac_chan_if ci ();                              // Link to the address generator

  // ----------------------------------------------------------------
  // Channel indexing
  // ----------------------------------------------------------------
  // Code 7 is never used as an array index; it falls back to 0 but is masked
  always_comb begin
    sel_ok = (sel_r < 3'(BDMAC_NUM_CH));
    sel_idx = sel_ok ? sel_r : BDMAC_SEL_RST;
    act_ok = (XFER_CH_I < 3'(BDMAC_NUM_CH));
    // Engine code 7 means idle; its fallback index is never acted on
    act_idx = act_ok ? XFER_CH_I : BDMAC_SEL_RST;
  end

  // ----------------------------------------------------------------
  // Channel select register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      sel_r <= BDMAC_SEL_RST;
    end else if (SFR_WR_I && (SFR_ADDR_I == BDMAC_SEL_ADDR)) begin
      // Code 7 is kept as written; indirect access is then blocked
      sel_r <= SFR_WDATA_I[BDMAC_SEL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Per-channel indirect registers
  // ----------------------------------------------------------------
  // Writes only reach the channel named by the select register; with
  // select code 7 every indirect write is dropped
  for (genvar g = 0; g < BDMAC_NUM_CH; g++) begin : g_ch
    logic wr_ch;                                    // Indirect write to this channel
    logic hw_adv;                                   // Engine advances this channel
    assign wr_ch = SFR_WR_I && sel_ok && (sel_r == 3'(g));
    assign hw_adv = ci.adv && (act_idx == 3'(g));

    // Configuration byte
    always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
        cfg_r[g] <= BDMAC_CFG_RST;
      end else if (wr_ch && (SFR_ADDR_I == BDMAC_CFG_ADDR)) begin
        cfg_r[g] <= SFR_WDATA_I;
      end
    end

    // Base address, low byte and four high bits
    always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
        base_r[g] <= BDMAC_BASE_RST;
      end else if (wr_ch && (SFR_ADDR_I == BDMAC_BAL_ADDR)) begin
        base_r[g][7:0] <= SFR_WDATA_I;
      end else if (wr_ch && (SFR_ADDR_I == BDMAC_BAH_ADDR)) begin
        // Upper nibble of the write is discarded
        base_r[g][BDMAC_BASE_W-1:8] <= SFR_WDATA_I[BDMAC_BAH_W-1:0];
      end
    end

    // Offset: a software write beats an engine advance in the same cycle
    // The engine may lose that byte; software owns the restart
    always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
        ofs_r[g] <= BDMAC_OFS_RST;
      end else if (wr_ch && (SFR_ADDR_I == BDMAC_AOL_ADDR)) begin
        ofs_r[g][7:0] <= SFR_WDATA_I;
      end else if (wr_ch && (SFR_ADDR_I == BDMAC_AOH_ADDR)) begin
        ofs_r[g][BDMAC_OFS_W-1:8] <= SFR_WDATA_I[BDMAC_AOH_W-1:0];
      end else if (hw_adv) begin
        ofs_r[g] <= ci.ofs_nxt;
      end
    end

    // Transfer size
    always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
        size_r[g] <= BDMAC_SIZE_RST;
      end else if (wr_ch && (SFR_ADDR_I == BDMAC_SZL_ADDR)) begin
        size_r[g][7:0] <= SFR_WDATA_I;
      end else if (wr_ch && (SFR_ADDR_I == BDMAC_SZH_ADDR)) begin
        size_r[g][BDMAC_OFS_W-1:8] <= SFR_WDATA_I[BDMAC_AOH_W-1:0];
      end
    end

    // Wrap enable; the other mode bits are dropped
    // Only bit 0 is stored per channel
    always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
        wrap_r[g] <= BDMAC_WRAP_RST;
      end else if (wr_ch && (SFR_ADDR_I == BDMAC_MODE_ADDR)) begin
        wrap_r[g] <= SFR_WDATA_I[BDMAC_MODE_WRAP_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  // Unmapped addresses, and indirect registers under an invalid select, read as zero
  always_comb begin
    rdata_nxt = 8'h00;
    case (SFR_ADDR_I)
      BDMAC_SEL_ADDR: begin
        rdata_nxt = {5'h00, sel_r};
      end
      BDMAC_CFG_ADDR: begin
        if (sel_ok) rdata_nxt = cfg_r[sel_idx];
      end
      BDMAC_BAL_ADDR: begin
        if (sel_ok) rdata_nxt = base_r[sel_idx][7:0];
      end
      BDMAC_BAH_ADDR: begin
        // Upper nibble always reads zero
        if (sel_ok) rdata_nxt = {4'h0, base_r[sel_idx][BDMAC_BASE_W-1:8]};
      end
      BDMAC_AOL_ADDR: begin
        if (sel_ok) rdata_nxt = ofs_r[sel_idx][7:0];
      end
      BDMAC_AOH_ADDR: begin
        if (sel_ok) rdata_nxt = {6'h00, ofs_r[sel_idx][BDMAC_OFS_W-1:8]};
      end
      BDMAC_SZL_ADDR: begin
        if (sel_ok) rdata_nxt = size_r[sel_idx][7:0];
      end
      BDMAC_SZH_ADDR: begin
        if (sel_ok) rdata_nxt = {6'h00, size_r[sel_idx][BDMAC_OFS_W-1:8]};
      end
      BDMAC_MODE_ADDR: begin
        if (sel_ok) rdata_nxt = {7'h00, wrap_r[sel_idx]};
      end
      default: begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  // Read data is captured on the read strobe and held until the next one
  // Costs a cycle of latency but keeps the output glitch-free
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rdata_r <= BDMAC_RDATA_RST;
    end else if (SFR_RD_I) begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Active channel feed to the address generator
  // ----------------------------------------------------------------
  always_comb begin
    ci.chan_ok = act_ok;
    ci.byte_done = XFER_BYTE_I;
    ci.base = base_r[act_idx];
    ci.ofs = ofs_r[act_idx];
    ci.size = size_r[act_idx];
    ci.wrap = wrap_r[act_idx];
    ci.stall = cfg_r[act_idx][BDMAC_CFG_STALL_BIT];
    ci.big_endian = cfg_r[act_idx][BDMAC_CFG_ENDIAN_BIT];
    ci.full_en = cfg_r[act_idx][BDMAC_CFG_FULL_EN_BIT];
    ci.mid_en = cfg_r[act_idx][BDMAC_CFG_MID_EN_BIT];
    ci.func = cfg_r[act_idx][BDMAC_CFG_FUNC_LSB +: BDMAC_FUNC_W];
    ci.width = XFER_WIDTH_I;
    ci.index = XFER_INDEX_I;
  end

  bdmac_addr_gen u_gen (
    .ci (ci)
  );

  // ----------------------------------------------------------------
  // Engine-facing outputs
  // ----------------------------------------------------------------
  // Address, target and lane follow the engine's channel one cycle later
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      addr_r <= BDMAC_BASE_RST;
      // Idle: no target, lane 0, nothing may move
      target_r <= '0;
      lane_r <= 2'h0;
      ok_r <= 1'b0;
    end else begin
      // Sampled every edge, so a channel switch shows a cycle later
      addr_r <= ci.addr;
      target_r <= ci.target;
      lane_r <= ci.lane;
      ok_r <= ci.move_ok;
    end
  end

  // Interrupt conditions are single-cycle pulses; flag logic lives elsewhere
  // Enables act before the register, so a disabled
  // channel never leaks a pulse
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      full_r <= 1'b0;
      mid_r <= 1'b0;
    end else begin
      full_r <= ci.full_hit;
      mid_r <= ci.mid_hit;
    end
  end

  // Stall mirror for the transfer sequencer
  // Covers every channel, so a stalled one can be
  // parked before the engine picks it again
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      stall_r <= '0;
    end else begin
      for (int i = 0; i < BDMAC_NUM_CH; i++) begin
        stall_r[i] <= cfg_r[i][BDMAC_CFG_STALL_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Each output is a plain copy of a flip-flop
  assign SFR_RDATA_O = rdata_r;
  assign RAM_ADDR_O = addr_r;
  assign FUNC_SEL_O = target_r;
  assign BYTE_LANE_O = lane_r;
  assign XFER_OK_O = ok_r;
  assign FULL_IRQ_O = full_r;
  assign MID_IRQ_O = mid_r;
  assign CH_STALL_O = stall_r;

endmodule

// file: testbench/bdmac_props.sv
// Port-level checks for the byte DMA channel configuration block
`timescale 1ns/1ps
module bdmac_props
  import bdmac_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic [BDMAC_SEL_W-1:0] XFER_CH_I,
  input wire logic XFER_BYTE_I,
  input wire logic [1:0] XFER_WIDTH_I,
  input wire logic [1:0] XFER_INDEX_I,
  input wire logic [7:0] SFR_RDATA_O,
  input wire logic [BDMAC_BASE_W-1:0] RAM_ADDR_O,
  input wire logic [BDMAC_NUM_FUNC-1:0] FUNC_SEL_O,
  input wire logic [1:0] BYTE_LANE_O,
  input wire logic XFER_OK_O,
  input wire logic FULL_IRQ_O,
  input wire logic MID_IRQ_O,
  input wire logic [BDMAC_NUM_CH-1:0] CH_STALL_O
);
  // ------------------------------------------------------------
  // One clock domain, reset masks every check
  // ------------------------------------------------------------
  default clocking dc @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);
  a_bah_unused: assert property (
    SFR_RD_I && SFR_ADDR_I == BDMAC_BAH_ADDR |=> SFR_RDATA_O[7:4] == 4'h0)
    else $error("base high upper bits not zero");
  a_aoh_unused: assert property (
    SFR_RD_I && SFR_ADDR_I == BDMAC_AOH_ADDR |=> SFR_RDATA_O[7:2] == 6'h00)
    else $error("offset high upper bits not zero");
  a_rdata_hold: assert property (
    !SFR_RD_I |=> $stable(SFR_RDATA_O))
    else $error("read data moved without a read");
  a_sel_rdback: assert property (
    SFR_WR_I && SFR_ADDR_I == BDMAC_SEL_ADDR ##2 SFR_RD_I && SFR_ADDR_I == BDMAC_SEL_ADDR
    |=> SFR_RDATA_O == ($past(SFR_WDATA_I, 3) & 8'h07))
    else $error("select read back wrong");
  a_bad_chan: assert property (
    XFER_CH_I == 3'h7 |=> !XFER_OK_O && FUNC_SEL_O == 9'h000)
    else $error("invalid channel allowed to move");
  a_ok_onehot: assert property (
    XFER_OK_O |-> $onehot(FUNC_SEL_O))
    else $error("target select not one-hot");
  a_idle_nosel: assert property (
    !XFER_OK_O |-> FUNC_SEL_O == 9'h000)
    else $error("target selected while blocked");
  a_single_lane: assert property (
    XFER_WIDTH_I <= 2'h1 |=> BYTE_LANE_O == 2'h0)
    else $error("single byte lane not zero");
  a_full_cause: assert property (
    FULL_IRQ_O |-> $past(XFER_BYTE_I) && XFER_OK_O)
    else $error("full pulse without a byte");
  a_mid_cause: assert property (
    MID_IRQ_O |-> $past(XFER_BYTE_I) && XFER_OK_O)
    else $error("mid pulse without a byte");
endmodule
bind bdmac_top bdmac_props bdmac_props_inst (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
  .SFR_ADDR_I(SFR_ADDR_I), .SFR_WR_I(SFR_WR_I), .SFR_RD_I(SFR_RD_I),
  .SFR_WDATA_I(SFR_WDATA_I), .XFER_CH_I(XFER_CH_I), .XFER_BYTE_I(XFER_BYTE_I),
  .XFER_WIDTH_I(XFER_WIDTH_I), .XFER_INDEX_I(XFER_INDEX_I), .SFR_RDATA_O(SFR_RDATA_O),
  .RAM_ADDR_O(RAM_ADDR_O), .FUNC_SEL_O(FUNC_SEL_O), .BYTE_LANE_O(BYTE_LANE_O),
  .XFER_OK_O(XFER_OK_O), .FULL_IRQ_O(FULL_IRQ_O), .MID_IRQ_O(MID_IRQ_O),
  .CH_STALL_O(CH_STALL_O));

// file: testbench/bdmac_eng_model.sv
// Behavioural transfer engine that consumes the channel settings
`timescale 1ns/1ps
module bdmac_eng_model
  import bdmac_pkg::*;
(
  input wire logic clk_i,
  output logic [BDMAC_SEL_W-1:0] ch_o,
  output logic byte_o,
  output logic [1:0] width_o,
  output logic [1:0] index_o
);
  // ------------------------------------------------------------
  // Idle on the invalid channel so nothing moves by accident
  // ------------------------------------------------------------
  initial begin
    ch_o = 3'h7;
    byte_o = 1'b0;
    width_o = 2'h1;
    index_o = 2'h0;
  end
  // Shape settles a cycle ahead, then bytes go back to back
  task automatic burst(input logic [2:0] ch, input int n, input logic [1:0] w, ix);
    @(negedge clk_i);
    ch_o = ch;
    width_o = w;
    index_o = ix;
    repeat (n) begin
      @(negedge clk_i);
      byte_o = 1'b1;
    end
    @(negedge clk_i);
    byte_o = 1'b0;
  endtask
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the byte DMA channel configuration block
`timescale 1ns/1ps
module tb_top;
  import bdmac_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [2:0] xch;
  logic xbyte;
  logic [1:0] xw;
  logic [1:0] xi;
  logic [7:0] rdata;
  logic [11:0] xaddr;
  logic [8:0] psel;
  logic [1:0] lane;
  logic ok;
  logic firq;
  logic mirq;
  logic [6:0] stall;
  int errors = 0;
  int checks_done = 0;
  int n_full = 0;
  int n_mid = 0;
  always #4 clk_sys = ~clk_sys;
  // Pulses are counted on the falling edge, away from the launching edge
  always @(negedge clk_sys) begin
    if (firq === 1'b1) n_full++;
    if (mirq === 1'b1) n_mid++;
  end
  bdmac_top bdmac_top_inst (.CLK_SYS_I(clk_sys), .RST_I(rst), .SFR_ADDR_I(addr),
    .SFR_WR_I(wr_s), .SFR_RD_I(rd_s), .SFR_WDATA_I(wdata), .XFER_CH_I(xch),
    .XFER_BYTE_I(xbyte), .XFER_WIDTH_I(xw), .XFER_INDEX_I(xi), .SFR_RDATA_O(rdata),
    .RAM_ADDR_O(xaddr), .FUNC_SEL_O(psel), .BYTE_LANE_O(lane), .XFER_OK_O(ok),
    .FULL_IRQ_O(firq), .MID_IRQ_O(mirq), .CH_STALL_O(stall));
  bdmac_eng_model bdmac_eng_model_inst (.clk_i(clk_sys), .ch_o(xch), .byte_o(xbyte),
    .width_o(xw), .index_o(xi));
  // ------------------------------------------------------------
  // Shared bus cycles and comparison
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_sys);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk_sys);
    wr_s = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, exp, input string nm);
    @(negedge clk_sys);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk_sys);
    rd_s = 1'b0;
    chk(nm, {8'h00, exp}, {8'h00, rdata});
  endtask
  // Offset cleared before each run, as software should
  task automatic prep(input logic [7:0] cfg, mode);
    wr(BDMAC_CFG_ADDR, cfg);
    wr(BDMAC_MODE_ADDR, mode);
    wr(BDMAC_AOL_ADDR, 8'h00);
    wr(BDMAC_AOH_ADDR, 8'h00);
    n_full = 0;
    n_mid = 0;
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    for (int c = 0; c < BDMAC_NUM_CH; c++) begin
      wr(BDMAC_SEL_ADDR, 8'(c));
      wr(BDMAC_CFG_ADDR, 8'h40 | 8'(c));
      wr(BDMAC_BAH_ADDR, 8'hf0 | 8'(c));
      wr(BDMAC_AOH_ADDR, 8'hfc | 8'(c));
    end
    for (int c = 0; c < BDMAC_NUM_CH; c++) begin
      wr(BDMAC_SEL_ADDR, 8'(c));
      rdc(BDMAC_CFG_ADDR, 8'h40 | 8'(c), "cfg");
      rdc(BDMAC_BAH_ADDR, 8'(c), "bah");
      rdc(BDMAC_AOH_ADDR, 8'(c) & 8'h03, "aoh");
    end
    wr(BDMAC_SEL_ADDR, 8'h07);
    rdc(BDMAC_SEL_ADDR, 8'h07, "sel");
    wr(BDMAC_CFG_ADDR, 8'hff);
    rdc(BDMAC_CFG_ADDR, 8'h00, "cfg sel7");
    wr(BDMAC_SEL_ADDR, 8'h00);
    rdc(BDMAC_CFG_ADDR, 8'h40, "cfg ch0");
  endtask
  task automatic t_move();
    wr(BDMAC_SEL_ADDR, 8'h02);
    wr(BDMAC_BAL_ADDR, 8'ha5);
    wr(BDMAC_BAH_ADDR, 8'h03);
    wr(BDMAC_SZL_ADDR, 8'h04);
    wr(BDMAC_SZH_ADDR, 8'h00);
    for (int c = 0; c < 10; c++) begin
      prep(8'(c), 8'h00);
      bdmac_eng_model_inst.burst(3'h2, 1, 2'h1, 2'h0);
      @(negedge clk_sys);
      chk("psel", (c < 9) ? 16'h1 << c : 16'h0, {7'h0, psel});
      chk("xaddr", (c < 9) ? 16'h3a6 : 16'h3a5, {4'h0, xaddr});
    end
  endtask
  task automatic t_irq();
    logic [7:0] cf [3] = '{8'hc3, 8'h03, 8'hc3};
    int exp [3] = '{1, 0, 1};
    for (int k = 0; k < 3; k++) begin
      prep(cf[k], (k == 2) ? 8'h01 : 8'h00);
      bdmac_eng_model_inst.burst(3'h2, 4, 2'h1, 2'h0);
      repeat (2) @(negedge clk_sys);
      chk("full", 16'(exp[k]), 16'(n_full));
      chk("mid", 16'(exp[k]), 16'(n_mid));
      rdc(BDMAC_AOL_ADDR, (k == 2) ? 8'h00 : 8'h04, "ofs");
    end
  endtask
  task automatic t_stall();
    prep(8'h23, 8'h00);
    bdmac_eng_model_inst.burst(3'h2, 2, 2'h1, 2'h0);
    chk("stall", 16'h0004, {9'h0, stall});
    chk("ok", 16'h0, {15'h0, ok});
    rdc(BDMAC_AOL_ADDR, 8'h00, "ofs stalled");
    rdc(BDMAC_CFG_ADDR, 8'h23, "cfg stalled");
    wr(BDMAC_CFG_ADDR, 8'h03);
    bdmac_eng_model_inst.burst(3'h2, 1, 2'h1, 2'h0);
    rdc(BDMAC_AOL_ADDR, 8'h01, "ofs resumed");
  endtask
  task automatic t_lane();
    logic [7:0] cf [4] = '{8'h13, 8'h03, 8'h13, 8'h13};
    logic [1:0] w [4] = '{2'h3, 2'h3, 2'h1, 2'h2};
    logic [1:0] exp [4] = '{2'h2, 2'h0, 2'h0, 2'h0};
    for (int k = 0; k < 4; k++) begin
      prep(cf[k], 8'h00);
      bdmac_eng_model_inst.burst(3'h2, 1, w[k], (k == 3) ? 2'h1 : 2'h0);
      chk("lane", {14'h0, exp[k]}, {14'h0, lane});
    end
  endtask
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    chk("stall rst", 16'h0, {9'h0, stall});
    rdc(BDMAC_CFG_ADDR, 8'h00, "cfg rst");
    rdc(BDMAC_BAL_ADDR, 8'h00, "bal rst");
    rdc(BDMAC_AOH_ADDR, 8'h00, "aoh rst");
    t_regs();
    t_move();
    t_irq();
    t_stall();
    t_lane();
    tally_and_finish();
  end
  // Whole run needs a few hundred cycles, so this only cuts a hang
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
endmodule
